// ==== verification/i2c_master_props.sv ====
// concurrent checks on the bus master ports
`timescale 1ns/1ns
module i2c_master_props (
  // clock and reset
  input logic aclk,
  input logic aresetn,
  // register bus handshakes
  input logic s_axi_awvalid,
  input logic s_axi_awready,
  input logic s_axi_wvalid,
  input logic s_axi_wready,
  input logic s_axi_bvalid,
  input logic s_axi_arvalid,
  input logic s_axi_arready,
  input logic s_axi_rvalid,
  // bus lines
  input logic scl_in,
  input logic scl_oe,
  input logic sda_oe,
  // event
  input logic master_event_irq
);
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);
  start_order_a: assert property ($rose(sda_oe) && !scl_oe |-> ##[1:40] scl_oe)
    else $error("clock not pulled low after start data edge");
  data_on_low_a: assert property ($fell(sda_oe) |-> scl_oe)
    else $error("data line released while clock released");
  irq_clock_low_a: assert property ($rose(master_event_irq) |-> ##[0:2] scl_oe)
    else $error("event raised without clock held low");
  clock_held_a: assert property ($rose(master_event_irq) |-> ##3 scl_oe [*6])
    else $error("clock not held low after event");
  stretch_wait_a: assert property ($rose(scl_oe) |-> $past(scl_in, 3))
    else $error("clock pulled low before line seen high");
  write_resp_a: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
    |-> ##[1:3] s_axi_bvalid)
    else $error("write response late");
  read_resp_a: assert property (s_axi_arvalid && s_axi_arready |-> ##[1:2] s_axi_rvalid)
    else $error("read response late");
  ready_block_a: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
    else $error("write accepted while response pending");
endmodule
bind i2c_master_start_and_transmit i2c_master_props u_props (
  .aclk(aclk), .aresetn(aresetn), .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
  .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready), .s_axi_bvalid(s_axi_bvalid),
  .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready), .s_axi_rvalid(s_axi_rvalid),
  .scl_in(scl_in), .scl_oe(scl_oe), .sda_oe(sda_oe), .master_event_irq(master_event_irq)
);

// ==== verification/i2c_slave_model.sv ====
// behavioural bus slave: captures bytes, answers the ninth clock, may stretch the clock
`timescale 1ns/1ns
module i2c_slave_model (
  // bus lines
  input wire scl,
  input wire sda,
  output reg scl_low,
  output reg sda_low,
  // behaviour
  input wire ack_en,
  input wire stretch_en,
  // observed
  output reg [7:0] rx_byte,
  output reg start_seen
);
  integer nbit;
  initial begin
    scl_low = 1'b0;
    sda_low = 1'b0;
    rx_byte = 8'h00;
    start_seen = 1'b0;
    nbit = 0;
  end
  always @(negedge sda) begin
    if (scl === 1'b1) begin
      start_seen = 1'b1;
      nbit = 0;
    end
  end
  always @(posedge sda) begin
    if (scl === 1'b1)
      start_seen = 1'b0;
  end
  always @(posedge scl) begin
    if (nbit < 8)
      rx_byte = {rx_byte[6:0], sda};
    nbit = nbit + 1;
  end
  always @(negedge scl) begin
    if (nbit == 8)
      sda_low = ack_en;
    if (nbit == 9) begin
      sda_low = 1'b0;
      nbit = 0;
    end
    if (stretch_en) begin
      scl_low = 1'b1;
      #300;
      scl_low = 1'b0;
    end
  end
endmodule

// ==== verification/testbench.sv ====
// self-checking bench for the start and byte transmit bus master
`timescale 1ns/1ns
`include "i2c_master_regs.vh"
module testbench;
  reg aclk;
  reg aresetn;
  reg [3:0] awaddr;
  reg [3:0] araddr;
  reg [31:0] wdata;
  reg [3:0] wstrb;
  reg awvalid, wvalid, bready, arvalid, rready, ack_en, stretch_en, bus_sda_low;
  wire awready, wready, bvalid, arready, rvalid, scl_out, scl_oe, sda_out, sda_oe, irq;
  wire [1:0] bresp;
  wire [1:0] rresp;
  wire [31:0] rdata;
  wire slv_scl_low, slv_sda_low, slv_start;
  wire [7:0] slv_byte;
  wire scl_line = (scl_oe ? scl_out : 1'b1) & ~slv_scl_low;
  wire sda_line = (sda_oe ? sda_out : 1'b1) & ~slv_sda_low & ~bus_sda_low;
  integer n_errors, cmp_count, i, n;
  reg [1:0] resp;
  reg [31:0] val;
  reg [7:0] tx_bytes [0:2];

  i2c_master_start_and_transmit u_dut (.aclk(aclk), .aresetn(aresetn),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .scl_in(scl_line), .scl_out(scl_out), .scl_oe(scl_oe),
    .sda_in(sda_line), .sda_out(sda_out), .sda_oe(sda_oe), .master_event_irq(irq));
  i2c_slave_model u_slave (.scl(scl_line), .sda(sda_line), .scl_low(slv_scl_low), .sda_low(slv_sda_low),
    .ack_en(ack_en), .stretch_en(stretch_en), .rx_byte(slv_byte), .start_seen(slv_start));

  initial begin
    aclk = 1'b0;
    forever #5 aclk = ~aclk;
  end

  task check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    begin
      cmp_count = cmp_count + 1;
      if (seen !== exp) begin
        n_errors = n_errors + 1;
        $display("Error %s expected %h seen %h", name, exp, seen);
      end
    end
  endtask
  task st_bit(input string name, input integer b, input logic e);
    check(name, {31'h0, val[b]}, {31'h0, e});
  endtask
  task axi_write(input [3:0] a, input [31:0] d, input [3:0] s, output [1:0] r);
    begin
      awaddr <= a;
      wdata <= d;
      wstrb <= s;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      @(posedge aclk);
      while (awvalid || wvalid) begin
        if (awready) awvalid <= 1'b0;
        if (wready) wvalid <= 1'b0;
        @(posedge aclk);
      end
      while (bvalid !== 1'b1) @(posedge aclk);
      r = bresp;
    end
  endtask
  task axi_read(input [3:0] a, output [31:0] d, output [1:0] r);
    begin
      araddr <= a;
      arvalid <= 1'b1;
      @(posedge aclk);
      while (arready !== 1'b1) @(posedge aclk);
      arvalid <= 1'b0;
      @(posedge aclk);
      while (rvalid !== 1'b1) @(posedge aclk);
      d = rdata;
      r = rresp;
    end
  endtask
  task wait_irq;
    begin
      for (n = 0; n < 4000 && irq !== 1'b1; n = n + 1) @(posedge aclk);
      check("event", {31'h0, irq}, 32'h1);
    end
  endtask
  task clear_flags;
    begin
      axi_write(`STATUS_REG_ADDR, 32'h00010000, 4'h5, resp);
      axi_read(`STATUS_REG_ADDR, val, resp);
      st_bit("wcol clear", `ST_WCOL_BIT, 1'b0);
      st_bit("irq clear", `ST_IRQ_BIT, 1'b0);
    end
  endtask
  task print_verdict;
    begin
      $display("errors %0d comparisons %0d", n_errors, cmp_count);
      if (n_errors == 0 && cmp_count > 0)
        $display("bench passed");
      else
        $display("bench failed");
      $finish;
    end
  endtask

  initial begin
    #100000;
    n_errors = n_errors + 1;
    print_verdict;
  end

  initial begin
    n_errors = 0;
    cmp_count = 0;
    aresetn = 1'b0;
    {awaddr, araddr, wdata, wstrb, awvalid, wvalid, arvalid, ack_en, stretch_en, bus_sda_low} = 0;
    bready = 1'b1;
    rready = 1'b1;
    // 7-bit address with read direction, then first 10-bit address byte for write and for read
    tx_bytes[0] = 8'hA5;
    tx_bytes[1] = 8'hF2;
    tx_bytes[2] = 8'hF3;
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    axi_read(`BAUD_RELOAD_REG_ADDR, val, resp);
    check("baud reset", val, {20'h0, `BAUD_RESET});
    axi_read(`CONTROL_REG_ADDR, val, resp);
    check("control reset", val, `CONTROL_RESET);
    axi_write(4'h2, 32'hFFFFFFFF, 4'hF, resp);
    check("unmapped wresp", {30'h0, resp}, 32'h2);
    axi_read(4'h2, val, resp);
    check("unmapped rresp", {30'h0, resp}, 32'h2);
    check("unmapped data", val, 32'h0);
    axi_write(`BAUD_RELOAD_REG_ADDR, 32'h0000000C, 4'hF, resp);
    axi_read(`BAUD_RELOAD_REG_ADDR, val, resp);
    check("baud", val, 32'h0000000C);
    // another bus user leaves a start and a stop, so the bus reads idle before the master starts
    bus_sda_low <= 1'b1;
    repeat (6) @(posedge aclk);
    bus_sda_low <= 1'b0;
    repeat (6) @(posedge aclk);
    axi_read(`STATUS_REG_ADDR, val, resp);
    st_bit("idle stop", `ST_STOP_BIT, 1'b1);
    st_bit("idle start", `ST_START_BIT, 1'b0);
    check("slave idle", {31'h0, slv_start}, 32'h0);
    // start, then a transmit write and a command clear while it runs
    axi_write(`CONTROL_REG_ADDR, 32'h1, 4'h1, resp);
    axi_write(`TX_HOLDING_REG_ADDR, 32'hFF, 4'h1, resp);
    axi_write(`CONTROL_REG_ADDR, 32'h0, 4'h1, resp);
    wait_irq;
    axi_read(`STATUS_REG_ADDR, val, resp);
    st_bit("wcol start", `ST_WCOL_BIT, 1'b1);
    st_bit("tbf start", `ST_TBF_BIT, 1'b0);
    st_bit("start seen", `ST_START_BIT, 1'b1);
    st_bit("stop seen", `ST_STOP_BIT, 1'b0);
    axi_read(`CONTROL_REG_ADDR, val, resp);
    st_bit("start req", `CTL_START_BIT, 1'b0);
    check("slave start", {31'h0, slv_start}, 32'h1);
    check("lines low", {30'h0, scl_line, sda_line}, 32'h0);
    clear_flags;
    for (i = 0; i < 3; i = i + 1) begin
      ack_en <= (i != 1);
      stretch_en <= (i == 1);
      if (i == 2) begin
        // let the last clock stretch run out, then start again from a held bus
        repeat (40) @(posedge aclk);
        axi_write(`CONTROL_REG_ADDR, 32'h1, 4'h1, resp);
        wait_irq;
        clear_flags;
      end
      axi_write(`TX_HOLDING_REG_ADDR, {24'h0, tx_bytes[i]}, 4'h1, resp);
      axi_read(`STATUS_REG_ADDR, val, resp);
      st_bit("tbf set", `ST_TBF_BIT, 1'b1);
      st_bit("txact set", `ST_TXACT_BIT, 1'b1);
      axi_write(`TX_HOLDING_REG_ADDR, 32'h0, 4'h1, resp);
      axi_write(`CONTROL_REG_ADDR, 32'h1, 4'h1, resp);
      wait_irq;
      axi_read(`STATUS_REG_ADDR, val, resp);
      st_bit("wcol tx", `ST_WCOL_BIT, 1'b1);
      st_bit("tbf done", `ST_TBF_BIT, 1'b0);
      st_bit("txact done", `ST_TXACT_BIT, 1'b0);
      st_bit("ack status", `ST_ACK_BIT, i == 1);
      check("byte", {24'h0, slv_byte}, {24'h0, tx_bytes[i]});
      axi_read(`CONTROL_REG_ADDR, val, resp);
      st_bit("cmd ignored", `CTL_START_BIT, 1'b0);
      check("clock low", {31'h0, scl_line}, 32'h0);
      clear_flags;
    end
    print_verdict;
  end
endmodule

// ==== verilog/baud_timer.v ====
// reload baud generator, two decrements per cycle, stops at zero
`timescale 1ns/1ns
module baud_timer #(
  parameter WIDTH = 12
) (
  // clock and reset
  input wire aclk,
  input wire aresetn,
  // control
  input wire load,
  input wire [WIDTH-1:0] reload,
  // state
  output reg expired
);
  reg [WIDTH-1:0] count;
  always @(posedge aclk) begin
    if (!aresetn) begin
      count <= {WIDTH{1'b0}};
      expired <= 1'b0;
    end else if (load) begin
      count <= reload;
      expired <= 1'b0;
    end else if (count > {{(WIDTH-2){1'b0}}, 2'b10}) begin
      count <= count - {{(WIDTH-2){1'b0}}, 2'b10};
    end else if (count != {WIDTH{1'b0}}) begin
      count <= {WIDTH{1'b0}};
      expired <= 1'b1;
    end else begin
      expired <= 1'b0;
    end
  end
endmodule

// ==== verilog/i2c_master_regs.vh ====
// register map, field positions, reset values and timing counts of the bus master
`ifndef I2C_MASTER_REGS_VH
`define I2C_MASTER_REGS_VH
`define CONTROL_REG_ADDR 4'h0
`define STATUS_REG_ADDR 4'h4
`define TX_HOLDING_REG_ADDR 4'h8
`define BAUD_RELOAD_REG_ADDR 4'hC
`define CTL_START_BIT 0
`define CTL_CMD_MASK 32'h0000001F
`define CTL_MONITOR_BIT 11
`define ST_ACK_BIT 15
`define ST_TXACT_BIT 14
`define ST_WCOL_BIT 7
`define ST_STOP_BIT 4
`define ST_START_BIT 3
`define ST_TBF_BIT 0
`define ST_IRQ_BIT 16
`define CONTROL_RESET 32'h00000000
`define BAUD_RESET 12'h004
`define BAUD_WIDTH 12
`endif

// ==== verilog/i2c_master_start_and_transmit.v ====
// two-wire bus master: start generation and byte transmit with acknowledge, AXI4-Lite registers
`timescale 1ns/1ns
`include "i2c_master_regs.vh"
module i2c_master_start_and_transmit (
  // clock and reset
  input wire aclk,
  input wire aresetn,
  // axi4-lite write address
  input wire [3:0] s_axi_awaddr,
  input wire s_axi_awvalid,
  output reg s_axi_awready,
  // axi4-lite write data
  input wire [31:0] s_axi_wdata,
  input wire [3:0] s_axi_wstrb,
  input wire s_axi_wvalid,
  output reg s_axi_wready,
  // axi4-lite write response
  output reg [1:0] s_axi_bresp,
  output reg s_axi_bvalid,
  input wire s_axi_bready,
  // axi4-lite read address
  input wire [3:0] s_axi_araddr,
  input wire s_axi_arvalid,
  output reg s_axi_arready,
  // axi4-lite read data
  output reg [31:0] s_axi_rdata,
  output reg [1:0] s_axi_rresp,
  output reg s_axi_rvalid,
  input wire s_axi_rready,
  // clock line
  input wire scl_in,
  output reg scl_out,
  output reg scl_oe,
  // data line
  input wire sda_in,
  output reg sda_out,
  output reg sda_oe,
  // event
  output reg master_event_irq
);
  localparam [1:0] RESP_OKAY = 2'b00;
  localparam [1:0] RESP_SLVERR = 2'b10;
  localparam [7:0] ST_IDLE = 8'h01;
  localparam [7:0] ST_START_A = 8'h02;
  localparam [7:0] ST_START_B = 8'h04;
  localparam [7:0] ST_TX_LOW = 8'h08;
  localparam [7:0] ST_TX_REL = 8'h10;
  localparam [7:0] ST_TX_HIGH = 8'h20;
  localparam [7:0] ST_ACK_REL = 8'h40;
  localparam [7:0] ST_ACK_HIGH = 8'h80;

  reg [7:0] state;
  reg [31:0] control_reg;
  reg [`BAUD_WIDTH-1:0] baud_reload_reg;
  reg [7:0] tx_holding_reg;
  reg [7:0] shifter;
  reg [3:0] bit_count;
  reg tx_buffer_full;
  reg ack_received_status;
  reg master_tx_active;
  reg write_collision_flag;
  reg start_seen;
  reg stop_seen;
  reg hold_scl_low;
  reg hold_sda_low;
  reg baud_load;
  reg aw_held;
  reg w_held;
  reg [3:0] aw_addr;
  reg [31:0] w_data;
  reg [3:0] w_strb;
  wire baud_expired;
  wire scl_s;
  wire sda_s;
  wire scl_fell;
  wire sda_fell;
  wire sda_rose;
  wire busy;
  wire do_write;
  wire tx_write;
  wire start_cmd;
  wire set_collision;
  wire set_event;
  wire clear_event;
  wire [31:0] status_word;

  baud_timer #(
    .WIDTH(`BAUD_WIDTH)
  ) u_baud (
    .aclk(aclk),
    .aresetn(aresetn),
    .load(baud_load),
    .reload(baud_reload_reg),
    .expired(baud_expired)
  );

  line_sync u_scl (
    .aclk(aclk),
    .aresetn(aresetn),
    .line_in(scl_in),
    .line(scl_s),
    .fell(scl_fell),
    .rose()
  );

  line_sync u_sda (
    .aclk(aclk),
    .aresetn(aresetn),
    .line_in(sda_in),
    .line(sda_s),
    .fell(sda_fell),
    .rose(sda_rose)
  );

  // write channel: address and data taken in either order, executed once both held
  assign do_write = aw_held & w_held & ~s_axi_bvalid;
  assign busy = (state != ST_IDLE) | control_reg[`CTL_START_BIT];
  assign tx_write = do_write & (aw_addr == `TX_HOLDING_REG_ADDR) & w_strb[0];
  assign set_collision = tx_write & busy;
  assign start_cmd = state == ST_IDLE && control_reg[`CTL_START_BIT];
  // master event: bit 16 of status, write one to clear; set wins over clear
  assign clear_event = do_write & (aw_addr == `STATUS_REG_ADDR) & w_strb[2] & w_data[`ST_IRQ_BIT];
  assign set_event = ((state == ST_START_B) & baud_expired) | ((state == ST_ACK_HIGH) & scl_fell);
  assign status_word = {15'h0000, master_event_irq, ack_received_status, master_tx_active, 6'h00,
                        write_collision_flag, 2'b00, stop_seen, start_seen, 2'b00, tx_buffer_full};

  always @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_awready <= 1'b1;
      s_axi_wready <= 1'b1;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= RESP_OKAY;
      aw_held <= 1'b0;
      w_held <= 1'b0;
      aw_addr <= 4'h0;
      w_data <= 32'h00000000;
      w_strb <= 4'h0;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_addr <= s_axi_awaddr;
        aw_held <= 1'b1;
        s_axi_awready <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_data <= s_axi_wdata;
        w_strb <= s_axi_wstrb;
        w_held <= 1'b1;
        s_axi_wready <= 1'b0;
      end
      if (do_write) begin
        s_axi_bvalid <= 1'b1;
        aw_held <= 1'b0;
        w_held <= 1'b0;
        s_axi_bresp <= (aw_addr[1:0] == 2'b00) ? RESP_OKAY : RESP_SLVERR; // every aligned word is mapped
      end
      if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
        s_axi_awready <= 1'b1;
        s_axi_wready <= 1'b1;
      end
    end
  end

  // read channel
  always @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_arready <= 1'b1;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h00000000;
      s_axi_rresp <= RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b1;
      s_axi_rresp <= RESP_OKAY;
      case (s_axi_araddr)
        `CONTROL_REG_ADDR: s_axi_rdata <= control_reg;
        `STATUS_REG_ADDR: s_axi_rdata <= status_word;
        `TX_HOLDING_REG_ADDR: s_axi_rdata <= {24'h000000, tx_holding_reg};
        `BAUD_RELOAD_REG_ADDR: s_axi_rdata <= {20'h00000, baud_reload_reg};
        default: begin
          s_axi_rdata <= 32'h00000000;
          s_axi_rresp <= RESP_SLVERR;
        end
      endcase
    end else if (s_axi_rvalid && s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
      s_axi_arready <= 1'b1;
    end
  end

  // registers written by software, and the flags they share with the sequencer
  always @(posedge aclk) begin
    if (!aresetn) begin
      control_reg <= `CONTROL_RESET;
      baud_reload_reg <= `BAUD_RESET;
      tx_holding_reg <= 8'h00;
      write_collision_flag <= 1'b0;
      master_event_irq <= 1'b0;
    end else begin
      if (do_write && aw_addr == `CONTROL_REG_ADDR) begin
        if (w_strb[1]) begin
          control_reg[15:8] <= w_data[15:8];
        end
        if (w_strb[0]) begin
          control_reg[7:5] <= w_data[7:5];
          if (!busy) begin
            control_reg[4:0] <= w_data[4:0];
          end
        end
      end
      if (do_write && aw_addr == `BAUD_RELOAD_REG_ADDR) begin
        if (w_strb[0]) begin
          baud_reload_reg[7:0] <= w_data[7:0];
        end
        if (w_strb[1]) begin
          baud_reload_reg[`BAUD_WIDTH-1:8] <= w_data[`BAUD_WIDTH-1:8];
        end
      end
      if (tx_write && !busy) begin
        tx_holding_reg <= w_data[7:0];
      end
      if (set_collision) begin
        write_collision_flag <= 1'b1;
      end else if (do_write && aw_addr == `STATUS_REG_ADDR && w_strb[0] && !w_data[`ST_WCOL_BIT]) begin
        write_collision_flag <= 1'b0;
      end
      if (set_event) begin
        master_event_irq <= 1'b1;
      end else if (clear_event) begin
        master_event_irq <= 1'b0;
      end
      if (state == ST_START_B && baud_expired) begin
        control_reg[`CTL_START_BIT] <= 1'b0;
      end
    end
  end

  // bus monitor: start is data falling with clock high, stop is data rising with clock high
  always @(posedge aclk) begin
    if (!aresetn) begin
      start_seen <= 1'b0;
      stop_seen <= 1'b0;
    end else if (sda_fell && scl_s) begin
      start_seen <= 1'b1;
      stop_seen <= 1'b0;
    end else if (sda_rose && scl_s) begin
      start_seen <= 1'b0;
      stop_seen <= 1'b1;
    end
  end

  // master sequencer
  always @(posedge aclk) begin
    if (!aresetn) begin
      state <= ST_IDLE;
      baud_load <= 1'b0;
      hold_scl_low <= 1'b0;
      hold_sda_low <= 1'b0;
      shifter <= 8'h00;
      bit_count <= 4'h0;
      tx_buffer_full <= 1'b0;
      ack_received_status <= 1'b0;
      master_tx_active <= 1'b0;
    end else begin
      baud_load <= 1'b0;
      case (state)
        ST_IDLE: begin
          if (start_cmd) begin
            baud_load <= 1'b1;
            hold_sda_low <= 1'b0;
            hold_scl_low <= 1'b0;
            state <= ST_START_A;
          end else if (tx_write) begin
            shifter <= w_data[7:0];
            tx_buffer_full <= 1'b1;
            master_tx_active <= 1'b1;
            bit_count <= 4'h0;
            hold_scl_low <= 1'b1;
            hold_sda_low <= ~w_data[7];
            baud_load <= 1'b1;
            state <= ST_TX_LOW;
          end
        end
        ST_START_A: begin
          if (baud_expired && !baud_load) begin
            hold_sda_low <= 1'b1;
            baud_load <= 1'b1;
            state <= ST_START_B;
          end
        end
        ST_START_B: begin
          if (baud_expired && !baud_load) begin
            hold_scl_low <= 1'b1;
            state <= ST_IDLE;
          end
        end
        ST_TX_LOW: begin
          if (baud_expired && !baud_load) begin
            hold_scl_low <= 1'b0;
            state <= ST_TX_REL;
          end
        end
        ST_TX_REL: begin
          if (scl_s) begin
            baud_load <= 1'b1;
            state <= ST_TX_HIGH;
          end
        end
        ST_TX_HIGH: begin
          if (baud_expired && !baud_load) begin
            hold_scl_low <= 1'b1;
            baud_load <= 1'b1;
            if (bit_count == 4'h7) begin
              tx_buffer_full <= 1'b0;
              hold_sda_low <= 1'b0;
              state <= ST_ACK_REL;
            end else begin
              shifter <= {shifter[6:0], 1'b0};
              hold_sda_low <= ~shifter[6];
              bit_count <= bit_count + 4'h1;
              state <= ST_TX_LOW;
            end
          end
        end
        ST_ACK_REL: begin
          if (baud_expired && !baud_load) begin
            hold_scl_low <= 1'b0;
          end
          if (!hold_scl_low && scl_s) begin
            baud_load <= 1'b1;
            state <= ST_ACK_HIGH;
          end
        end
        ST_ACK_HIGH: begin
          if (baud_expired && !baud_load && !hold_scl_low) begin
            ack_received_status <= sda_s;
            hold_scl_low <= 1'b1;
          end
          if (scl_fell) begin
            master_tx_active <= 1'b0;
            state <= ST_IDLE;
          end
        end
        default: begin
          state <= ST_IDLE;
        end
      endcase
    end
  end

  // open-drain pins: drive low only
  always @(posedge aclk) begin
    if (!aresetn) begin
      scl_out <= 1'b0;
      sda_out <= 1'b0;
      scl_oe <= 1'b0;
      sda_oe <= 1'b0;
    end else begin
      scl_out <= 1'b0;
      sda_out <= 1'b0;
      scl_oe <= hold_scl_low;
      if (scl_oe || !hold_scl_low) begin // data moves once the clock pin is already low, or while the clock is not being held low
        sda_oe <= hold_sda_low;
      end
    end
  end
endmodule

// ==== verilog/line_sync.v ====
// two-stage synchroniser for the bus lines, with edge detect on the settled stage
`timescale 1ns/1ns
module line_sync (
  // clock and reset
  input wire aclk,
  input wire aresetn,
  // raw line
  input wire line_in,
  // synchronised
  output reg line,
  output wire fell,
  output wire rose
);
  reg meta;
  reg prev;
  always @(posedge aclk) begin
    if (!aresetn) begin
      meta <= 1'b1;
      line <= 1'b1;
      prev <= 1'b1;
    end else begin
      meta <= line_in;
      line <= meta;
      prev <= line;
    end
  end
  assign fell = prev & ~line;
  assign rose = ~prev & line;
endmodule
